// [rtl/gdrl_map.svh]
// constants of the gate driver reset and configuration lock block
`ifndef GDRL_MAP_SVH
`define GDRL_MAP_SVH

// spi word width, parity bit in the top position
`define GDRL_SPI_WIDTH 16
// cycles the own reset-pin drive masks the sampled pin level
`define GDRL_PIN_HOLDOFF 3
// static config default: parity check on, both routings off
`define GDRL_CFG_RST 3'h4
`define GDRL_CFG_SHADOW_RST 3'h3
`define GDRL_FLAGS_RST 6'h00
`define GDRL_PINS_RST 7'h00

`endif

// [rtl/gdrl_pkg.sv]
// types of the gate driver reset and configuration lock block
package gdrl_pkg;

	typedef enum logic [1:0]
	{
		GDRL_MODE_ZERO = 2'h0,
		GDRL_MODE_RUN = 2'h1,
		GDRL_MODE_CONFIG = 2'h2
	} gdrl_mode_t;

	typedef struct packed
	{
		logic undervoltage;
		logic oscStartFail;
		logic refFault;
		logic memError;
	} gdrl_prim_evt_t;

	typedef struct packed
	{
		logic undervoltage;
		logic oscStartFail;
		logic oscMalfunction;
		logic refOpen;
		logic regulatorShort;
		logic memError;
	} gdrl_sec_evt_t;

	typedef struct packed
	{
		logic parityCheckEnable;
		logic tristateErrorToFaultAEn;
		logic monitorToFaultAEn;
	} gdrl_cfg_t;

	typedef struct packed
	{
		logic externalResetFlag;
		logic primaryResetFlag;
		logic primaryCommErrorFlag;
		logic secondaryReadyFlag;
		logic secondaryCommErrorFlag;
		logic secondaryResetFlag;
	} gdrl_flags_t;

	typedef struct packed
	{
		logic turnOnPin;
		logic turnOffPin;
		logic gatePin;
		logic stageTristate;
		logic desaturationClamp;
		logic activeClampInhibit;
		logic secondaryUndervoltage_n;
	} gdrl_sec_pins_t;

endpackage

// [rtl/gdrl_sync.sv]
// two-flop synchroniser for asynchronous levels
`timescale 1ns/100ps
module gdrl_sync
#(
	parameter int WIDTH = 1
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut_q
);

	logic [WIDTH-1:0] stage1_q;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			stage1_q <= '0;
			syncOut_q <= '0;
		end
		else if (clkEn)
		begin
			stage1_q <= asyncIn;
			syncOut_q <= stage1_q;
		end
	end

endmodule

// [rtl/gdrl_top.sv]
// reset event handling and static configuration lock of the gate driver
`timescale 1ns/100ps
`include "gdrl_map.svh"
module gdrl_top
#(
	parameter int SPI_W = `GDRL_SPI_WIDTH,
	parameter int HOLDOFF = `GDRL_PIN_HOLDOFF
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic resetReadyIn,
	input wire gdrl_pkg::gdrl_prim_evt_t primEvtIn,
	input wire gdrl_pkg::gdrl_sec_evt_t secEvtIn,
	input wire logic secCfgErrorIn,
	input wire logic lifesignIn,
	input wire logic outputDisablePin,
	input wire logic tristateErrorIn,
	input wire logic tristateControlIn,
	input wire logic enterConfigCmd,
	input wire logic leaveConfigCmd,
	input wire logic cfgWrValid,
	input wire gdrl_pkg::gdrl_cfg_t cfgWrData,
	input wire logic clearPrimaryFlags,
	input wire logic clearSecondaryFlags,
	input wire logic pwmOnReq,
	input wire logic rxWordValid,
	input wire logic [SPI_W-1:0] rxWord,
	input wire logic txDataValid,
	input wire logic [SPI_W-2:0] txData,
	input wire logic sdoIn,
	input wire logic doutIn,
	output logic resetReadyOut_q,
	output logic resetReadyOe_q,
	output logic faultA_n_q,
	output logic faultB_n_q,
	output logic sdoOut_q,
	output logic doutOut_q,
	output logic doutOe_q,
	output gdrl_pkg::gdrl_flags_t flags_q,
	output gdrl_pkg::gdrl_sec_pins_t secPins_q,
	output gdrl_pkg::gdrl_mode_t mode_q,
	output logic configLocked_q,
	output gdrl_pkg::gdrl_cfg_t cfg_q,
	output logic cfgWrRejected_q,
	output logic spiParityError_q,
	output logic rxWordOk_q,
	output logic [SPI_W-1:0] txWord_q,
	output logic txWordValid_q
);

	localparam int NS = $bits(gdrl_pkg::gdrl_prim_evt_t)
		+ $bits(gdrl_pkg::gdrl_sec_evt_t) + 6;

	// parity bit that makes the whole word hold an odd count of ones
	function automatic logic parityFill(input logic [SPI_W-2:0] data);
		return ~^data;
	endfunction

	logic [NS-1:0] syncBus;
	logic pinLevel;
	logic odis;
	logic tse;
	logic tsc;
	logic lifesign;
	logic secCfgErr;
	gdrl_pkg::gdrl_prim_evt_t primEvt;
	gdrl_pkg::gdrl_sec_evt_t secEvt;

	gdrl_sync #(.WIDTH(NS)) u_sync
	(
		.mclk(mclk),
		.nrst(nrst),
		.clkEn(clkEn),
		.asyncIn({resetReadyIn, outputDisablePin, tristateErrorIn,
			tristateControlIn, lifesignIn, secCfgErrorIn,
			primEvtIn, secEvtIn}),
		.syncOut_q(syncBus)
	);

	assign {pinLevel, odis, tse, tsc, lifesign, secCfgErr, primEvt,
		secEvt} = syncBus;

	logic [HOLDOFF-1:0] drvHist_q;
	logic primInReset_q;
	logic secFaultPrev_q;
	logic secHardPrev_q;
	logic tsePrev_q;
	logic tscPrev_q;
	logic faultAAct_q;
	logic faultBAct_q;
	gdrl_pkg::gdrl_cfg_t cfgShadow_q;

	// primary reset sources
	logic extReset;
	logic devCause;
	logic cfgBad;
	logic primCause;
	logic rstPrim;
	logic primEnd;
	// own drive masks the pin so it is not taken as an external reset
	assign extReset = !pinLevel && !resetReadyOe_q && !(|drvHist_q);
	assign cfgBad = cfg_q != ~cfgShadow_q;
	assign devCause = (|primEvt) || cfgBad;
	assign primCause = extReset || devCause;
	assign rstPrim = primCause || primInReset_q;
	assign primEnd = primInReset_q && !primCause;

	// secondary reset sources
	logic secHard;
	logic secHardAll;
	logic secSoft;
	logic secFault;
	logic cerSet;
	logic classB;
	logic anyReset;
	assign secHard = secEvt.undervoltage || secEvt.oscStartFail
		|| secEvt.memError || secEvt.refOpen || secCfgErr;
	assign secHardAll = secHard || secEvt.regulatorShort;
	assign secSoft = secEvt.oscMalfunction || rstPrim;
	assign secFault = secHardAll || secEvt.oscMalfunction;
	// reference open is the one secondary cause without comm error
	assign cerSet = secFault && !(secEvt.refOpen && !secEvt.undervoltage
		&& !secEvt.oscStartFail && !secEvt.memError && !secCfgErr
		&& !secEvt.oscMalfunction && !secEvt.regulatorShort);
	assign classB = primEnd || (secFault && !secFaultPrev_q);
	assign anyReset = rstPrim || secSoft || secHardAll;

	// operating mode
	gdrl_pkg::gdrl_mode_t modeNext;
	logic modeTrans;
	logic cfgAccept;
	logic leaveAccept;
	assign leaveAccept = leaveConfigCmd
		&& mode_q == gdrl_pkg::GDRL_MODE_CONFIG;
	always_comb
	begin
		modeNext = mode_q;
		unique case (mode_q)
			gdrl_pkg::GDRL_MODE_ZERO:
				if (enterConfigCmd)
					modeNext = gdrl_pkg::GDRL_MODE_CONFIG;
			gdrl_pkg::GDRL_MODE_CONFIG:
				if (leaveConfigCmd)
					modeNext = gdrl_pkg::GDRL_MODE_RUN;
			gdrl_pkg::GDRL_MODE_RUN:
				modeNext = gdrl_pkg::GDRL_MODE_RUN;
			default:
				modeNext = gdrl_pkg::GDRL_MODE_ZERO;
		endcase
		if (anyReset)
			modeNext = gdrl_pkg::GDRL_MODE_ZERO;
	end
	assign modeTrans = !anyReset && modeNext != mode_q;
	assign cfgAccept = cfgWrValid && !anyReset && !configLocked_q
		&& mode_q == gdrl_pkg::GDRL_MODE_CONFIG;

	// fault notifications, a set wins over a clear
	logic tseRise;
	logic tscRise;
	logic faSet;
	logic faultAAct_d;
	logic faultBAct_d;
	assign tseRise = tse && !tsePrev_q
		&& cfg_q.tristateErrorToFaultAEn;
	assign tscRise = tsc && !tscPrev_q && cfg_q.monitorToFaultAEn;
	assign faSet = modeTrans || tseRise || tscRise;
	assign faultAAct_d = !rstPrim
		&& (faSet || (faultAAct_q && !clearPrimaryFlags));
	assign faultBAct_d = classB
		|| (faultBAct_q && !clearPrimaryFlags);

	gdrl_pkg::gdrl_flags_t flagsD;
	assign flagsD.externalResetFlag = extReset
		|| (flags_q.externalResetFlag && !clearPrimaryFlags);
	assign flagsD.primaryResetFlag = extReset || primEnd
		|| (flags_q.primaryResetFlag && !clearPrimaryFlags);
	assign flagsD.primaryCommErrorFlag = cerSet
		|| (flags_q.primaryCommErrorFlag && !clearPrimaryFlags);
	assign flagsD.secondaryReadyFlag = !secFault;
	assign flagsD.secondaryCommErrorFlag = !lifesign
		|| (flags_q.secondaryCommErrorFlag && !clearSecondaryFlags);
	assign flagsD.secondaryResetFlag = (secHardPrev_q && !secHard)
		|| (flags_q.secondaryResetFlag && !clearSecondaryFlags);

	// secondary output stage
	logic stageOn;
	gdrl_pkg::gdrl_sec_pins_t pinsD;
	assign stageOn = pwmOnReq && !anyReset && !odis
		&& mode_q == gdrl_pkg::GDRL_MODE_RUN;
	assign pinsD.turnOnPin = stageOn;
	assign pinsD.turnOffPin = !stageOn && !odis && !secHardAll;
	assign pinsD.gatePin = stageOn;
	assign pinsD.stageTristate = odis && !secHardAll;
	assign pinsD.desaturationClamp = secHardAll || !stageOn;
	assign pinsD.activeClampInhibit = secHardAll;
	assign pinsD.secondaryUndervoltage_n = !secHardAll;

	// spi parity
	logic rxParityOk;
	assign rxParityOk =
		parityFill(rxWord[SPI_W-2:0]) == rxWord[SPI_W-1];

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			drvHist_q <= '1;
			primInReset_q <= 1'h1;
			secFaultPrev_q <= 1'h0;
			secHardPrev_q <= 1'h0;
			tsePrev_q <= 1'h0;
			tscPrev_q <= 1'h0;
			faultAAct_q <= 1'h0;
			faultBAct_q <= 1'h0;
			flags_q <= `GDRL_FLAGS_RST;
		end
		else if (clkEn)
		begin
			drvHist_q <= {drvHist_q[HOLDOFF-2:0], resetReadyOe_q};
			primInReset_q <= primCause;
			secFaultPrev_q <= secFault;
			secHardPrev_q <= secHard;
			tsePrev_q <= tse;
			tscPrev_q <= tsc;
			faultAAct_q <= faultAAct_d;
			faultBAct_q <= faultBAct_d;
			flags_q <= flagsD;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_q <= gdrl_pkg::GDRL_MODE_ZERO;
			configLocked_q <= 1'h0;
			cfg_q <= `GDRL_CFG_RST;
			cfgShadow_q <= `GDRL_CFG_SHADOW_RST;
			cfgWrRejected_q <= 1'h0;
		end
		else if (clkEn)
		begin
			mode_q <= modeNext;
			configLocked_q <= !anyReset
				&& (configLocked_q || leaveAccept);
			cfg_q <= anyReset ? `GDRL_CFG_RST
				: cfgAccept ? cfgWrData : cfg_q;
			cfgShadow_q <= anyReset ? `GDRL_CFG_SHADOW_RST
				: cfgAccept ? ~cfgWrData : cfgShadow_q;
			cfgWrRejected_q <= cfgWrValid && !cfgAccept;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			resetReadyOut_q <= 1'h0;
			resetReadyOe_q <= 1'h1;
			faultA_n_q <= 1'h1;
			faultB_n_q <= 1'h0;
			sdoOut_q <= 1'h0;
			doutOut_q <= 1'h0;
			doutOe_q <= 1'h0;
			secPins_q <= `GDRL_PINS_RST;
		end
		else if (clkEn)
		begin
			resetReadyOut_q <= 1'h0;
			resetReadyOe_q <= devCause;
			faultA_n_q <= rstPrim || !faultAAct_d;
			faultB_n_q <= !rstPrim && !faultBAct_d;
			sdoOut_q <= !rstPrim && sdoIn;
			doutOut_q <= doutIn;
			doutOe_q <= !rstPrim;
			secPins_q <= pinsD;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			spiParityError_q <= 1'h0;
			rxWordOk_q <= 1'h0;
			txWord_q <= '0;
			txWordValid_q <= 1'h0;
		end
		else if (clkEn)
		begin
			spiParityError_q <= rxWordValid && !rxParityOk
				&& cfg_q.parityCheckEnable;
			rxWordOk_q <= rxWordValid && (rxParityOk
				|| !cfg_q.parityCheckEnable);
			txWordValid_q <= txDataValid;
			if (txDataValid)
				txWord_q <= {parityFill(txData), txData};
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence sPrimEnd;
		clkEn && primInReset_q && !primCause;
	endsequence

	sequence sLeave;
		clkEn && leaveAccept && !anyReset;
	endsequence

	a_ext_reset_flags: assert property (clkEn && extReset |=>
		flags_q.externalResetFlag && flags_q.primaryResetFlag
		&& primInReset_q)
		else $error("external reset flags not set");

	a_ready_pin_drive: assert property (
		clkEn && (|primEvt) |=> resetReadyOe_q && !resetReadyOut_q)
		else $error("reset pin not driven low on primary fault");

	a_fault_b_end: assert property (sPrimEnd |=>
		!faultB_n_q && flags_q.primaryResetFlag)
		else $error("fault b or reset flag missing at reset end");

	a_disable_honoured: assert property (
		clkEn && odis && !secHardAll |=> secPins_q.stageTristate
		&& !secPins_q.turnOnPin)
		else $error("output disable not honoured");

	a_secondary_notify: assert property (clkEn && cerSet |=>
		flags_q.primaryCommErrorFlag && !flags_q.secondaryReadyFlag)
		else $error("secondary fault not notified");

	a_mode_zero_reset: assert property (
		clkEn && anyReset |=> mode_q == gdrl_pkg::GDRL_MODE_ZERO
		&& cfg_q == `GDRL_CFG_RST)
		else $error("reset did not restore mode zero defaults");

	a_primary_pins: assert property (clkEn && rstPrim |=>
		!sdoOut_q && faultA_n_q && !faultB_n_q && !doutOe_q)
		else $error("primary pin levels wrong in reset");

	a_secondary_pins: assert property (clkEn && secHardAll |=>
		secPins_q == 7'h06)
		else $error("secondary pin levels wrong in hard reset");

	a_cfg_write_gate: assert property (clkEn && cfgWrValid
		&& !anyReset && mode_q != gdrl_pkg::GDRL_MODE_CONFIG
		|=> $stable(cfg_q) && cfgWrRejected_q)
		else $error("static write taken outside config mode");

	a_cfg_frozen: assert property (sLeave |=>
		configLocked_q && mode_q == gdrl_pkg::GDRL_MODE_RUN
		##1 (!cfgWrRejected_q || $stable(cfg_q)))
		else $error("config not frozen after leave command");

	a_cfg_integrity: assert property (clkEn && cfgBad |=>
		primInReset_q ##0 !faultB_n_q)
		else $error("config mismatch caused no reset");

	a_rx_parity: assert property (clkEn && rxWordValid
		&& cfg_q.parityCheckEnable && !(^rxWord)
		|=> spiParityError_q && !rxWordOk_q)
		else $error("bad parity word not flagged");

	a_tx_parity: assert property (txWordValid_q |-> ^txWord_q)
		else $error("transmit word parity not odd");

	a_fault_a_route: assert property (clkEn && !rstPrim
		&& (tseRise || tscRise) |=> !faultA_n_q)
		else $error("tristate flag did not assert fault a");

	a_reset_release: assert property (sPrimEnd |=>
		!primInReset_q || primCause)
		else $error("primary reset not released on clear");

endmodule

// [verif/gdrl_host_model.sv]
// host controller model: reset wire and received spi words
`timescale 1ns/100ps
module gdrl_host_model
#(
	parameter int SPI_W = 16
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic holdReset,
	input wire logic deviceDrivesLow,
	input wire logic sendReq,
	input wire logic badParity,
	input wire logic [SPI_W-2:0] payload,
	output logic resetReadyWire,
	output logic rxWordValid,
	output logic [SPI_W-1:0] rxWord
);
	// pulled-up wire, low while either side pulls it
	assign resetReadyWire = !(holdReset || deviceDrivesLow);
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rxWordValid <= 1'b0;
			rxWord <= '0;
		end
		else
		begin
			rxWordValid <= sendReq;
			// idle word toggles so stale data never looks valid
			rxWord <= sendReq ? {(~^payload) ^ badParity, payload} : ~rxWord;
		end
	end
endmodule

// [verif/tb.sv]
// self-checking bench of the reset and configuration lock block
`timescale 1ns/100ps
`include "gdrl_map.svh"
module tb;
	logic mclk, nrst, resetReadyIn, lifesignIn, outputDisablePin;
	logic tristateErrorIn, tristateControlIn, enterConfigCmd, leaveConfigCmd;
	logic cfgWrValid, clearPrimaryFlags, clearSecondaryFlags, pwmOnReq;
	logic rxWordValid, txDataValid, secCfgErrorIn, holdReset, sendReq;
	logic badParity, resetReadyOe_q, faultA_n_q, faultB_n_q, sdoOut_q;
	logic doutOe_q, cfgWrRejected_q, spiParityError_q, rxWordOk_q;
	logic txWordValid_q, configLocked_q;
	logic sdoIn, doutIn, doutOut_q, resetReadyOut_q;
	logic [15:0] rxWord, txWord_q;
	logic [14:0] txData, payload;
	gdrl_pkg::gdrl_prim_evt_t primEvtIn;
	gdrl_pkg::gdrl_sec_evt_t secEvtIn;
	gdrl_pkg::gdrl_cfg_t cfgWrData, cfg_q;
	gdrl_pkg::gdrl_flags_t flags_q;
	gdrl_pkg::gdrl_sec_pins_t secPins_q;
	gdrl_pkg::gdrl_mode_t mode_q;
	int n_errors, checks;
	bit hard;

	gdrl_top dut (.mclk, .nrst, .clkEn(1'b1), .resetReadyIn, .primEvtIn,
		.secEvtIn, .secCfgErrorIn, .lifesignIn, .outputDisablePin,
		.tristateErrorIn, .tristateControlIn, .enterConfigCmd, .leaveConfigCmd,
		.cfgWrValid, .cfgWrData, .clearPrimaryFlags, .clearSecondaryFlags,
		.pwmOnReq, .rxWordValid, .rxWord, .txDataValid, .txData,
		.sdoIn, .doutIn, .resetReadyOut_q, .resetReadyOe_q,
		.faultA_n_q, .faultB_n_q, .sdoOut_q, .doutOut_q, .doutOe_q, .flags_q,
		.secPins_q, .mode_q, .configLocked_q, .cfg_q, .cfgWrRejected_q,
		.spiParityError_q, .rxWordOk_q, .txWord_q, .txWordValid_q);

	gdrl_host_model host (.mclk, .nrst, .holdReset,
		.deviceDrivesLow(resetReadyOe_q), .sendReq, .badParity, .payload,
		.resetReadyWire(resetReadyIn), .rxWordValid, .rxWord);

	function automatic logic exp_err(logic [14:0] p, logic b, logic en);
		return en & ~^{(~^p) ^ b, p};
	endfunction

	task automatic complete_run();
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input bit ok, input string m);
		checks++;
		if (!ok)
		begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// one-cycle strobe, result sampled after the taking edge
	task automatic strobe(input int k);
		@(posedge mclk);
		case (k)
			0: enterConfigCmd <= 1'b1;
			1: leaveConfigCmd <= 1'b1;
			2: cfgWrValid <= 1'b1;
			3: txDataValid <= 1'b1;
			4: {clearPrimaryFlags, clearSecondaryFlags} <= 2'b11;
			default: sendReq <= 1'b1;
		endcase
		@(posedge mclk);
		{enterConfigCmd, leaveConfigCmd, cfgWrValid, txDataValid} <= 4'h0;
		{clearPrimaryFlags, clearSecondaryFlags, sendReq} <= 3'h0;
		#1;
	endtask

	task automatic spi(input logic en);
		repeat (10)
		begin
			{badParity, payload, txData} <= 31'($urandom);
			strobe(5);
			wt(1);
			chk(spiParityError_q === exp_err(payload, badParity, en) &&
				rxWordOk_q === !exp_err(payload, badParity, en), "rx parity");
			strobe(3);
			chk(txWordValid_q === 1'b1 && txWord_q === {~^txData, txData},
				"tx parity");
		end
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial
	begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		$display("unexpected at %0t: run too long", $time);
		complete_run();
	end

	initial
	begin
		{nrst, outputDisablePin, tristateErrorIn, tristateControlIn} = 4'h0;
		{enterConfigCmd, leaveConfigCmd, cfgWrValid, pwmOnReq} = 4'h0;
		{clearPrimaryFlags, clearSecondaryFlags, txDataValid} = 3'h0;
		{secCfgErrorIn, holdReset, sendReq, badParity} = 4'h0;
		lifesignIn = 1'b1;
		{sdoIn, doutIn} = 2'b11;
		primEvtIn = '0;
		secEvtIn = '0;
		cfgWrData = '0;
		txData = '0;
		payload = '0;
		void'($urandom(32'h7ffb_eff2));
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		wt(8);
		chk(faultB_n_q === 1'b0 && flags_q.primaryResetFlag === 1'b1, "boot");
		strobe(4);
		chk(faultB_n_q === 1'b1, "fault b clear");
		spi(1'b1);
		cfgWrData <= 3'b011;
		strobe(2);
		chk(cfgWrRejected_q === 1'b1 && cfg_q === `GDRL_CFG_RST, "early write");
		strobe(0);
		chk(mode_q === gdrl_pkg::GDRL_MODE_CONFIG && faultA_n_q === 1'b0, "enter");
		strobe(2);
		chk(cfg_q === 3'b011 && cfgWrRejected_q === 1'b0, "config write");
		strobe(1);
		chk(mode_q === gdrl_pkg::GDRL_MODE_RUN && configLocked_q === 1'b1, "leave");
		cfgWrData <= 3'b100;
		strobe(2);
		chk(cfgWrRejected_q === 1'b1 && cfg_q === 3'b011, "locked write");
		spi(1'b0);
		for (int k = 0; k < 2; k++)
		begin
			strobe(4);
			chk(faultA_n_q === 1'b1, "fault a idle");
			{tristateErrorIn, tristateControlIn} <= k ? 2'b01 : 2'b10;
			wt(5);
			chk(faultA_n_q === 1'b0, "tristate to fault a");
			{tristateErrorIn, tristateControlIn} <= 2'b00;
		end
		for (int i = 0; i < 4; i++)
		begin
			primEvtIn <= 4'h8 >> i;
			{lifesignIn, outputDisablePin, pwmOnReq} <= 3'b011;
			wt(5);
			chk(resetReadyOe_q === 1'b1 && faultB_n_q === 1'b0 && faultA_n_q === 1'b1
				&& sdoOut_q === 1'b0 && doutOe_q === 1'b0
				&& resetReadyOut_q === 1'b0, "prim pins");
			chk(mode_q === gdrl_pkg::GDRL_MODE_ZERO && cfg_q === `GDRL_CFG_RST,
				"prim defaults");
			chk(secPins_q.turnOnPin === 1'b0 && secPins_q.stageTristate === 1'b1 &&
				flags_q.secondaryCommErrorFlag === 1'b1, "prim stage");
			primEvtIn <= '0;
			{lifesignIn, outputDisablePin, pwmOnReq} <= 3'b100;
			wt(6);
			chk(flags_q.primaryResetFlag === 1'b1 && faultB_n_q === 1'b0 &&
				flags_q.primaryCommErrorFlag === 1'b0 && resetReadyOe_q === 1'b0 &&
				flags_q.externalResetFlag === 1'b0, "prim end");
			chk(sdoOut_q === 1'b1 && doutOe_q === 1'b1 && doutOut_q === 1'b1,
				"prim pins end");
			strobe(4);
		end
		holdReset <= 1'b1;
		wt(6);
		holdReset <= 1'b0;
		wt(8);
		chk(flags_q.externalResetFlag === 1'b1 && flags_q.primaryResetFlag === 1'b1
			&& flags_q.primaryCommErrorFlag === 1'b0, "external reset");
		strobe(4);
		for (int i = 0; i < 7; i++)
		begin
			hard = i inside {0, 1, 3, 5, 6};
			if (i < 6)
				secEvtIn <= 6'h20 >> i;
			else
				secCfgErrorIn <= 1'b1;
			wt(5);
			chk(faultB_n_q === 1'b0 && flags_q.secondaryReadyFlag === 1'b0 &&
				mode_q === gdrl_pkg::GDRL_MODE_ZERO && secPins_q.turnOnPin === 1'b0,
				"sec notify");
			if (i != 3 && i != 6)
				chk(flags_q.primaryCommErrorFlag === 1'b1, "sec comm");
			if (hard)
				chk(secPins_q === 7'h06, "hard pins");
			if (i == 0 || i == 4)
				chk(secPins_q.secondaryUndervoltage_n === 1'b0, "uv out");
			secEvtIn <= '0;
			secCfgErrorIn <= 1'b0;
			wt(6);
			chk(flags_q.secondaryReadyFlag === 1'b1 &&
				flags_q.secondaryResetFlag === hard, "sec end");
			strobe(4);
		end
		complete_run();
	end
endmodule
